// ---- verilog/tpg_pkg.sv ----
package tpg_pkg;

  // Register byte offsets on the APB side
  localparam logic [11:0] TPG_ADDR_CTRL  = 12'h000;
  localparam logic [11:0] TPG_ADDR_USER0 = 12'h004;
  localparam logic [11:0] TPG_ADDR_USER1 = 12'h008;
  localparam logic [11:0] TPG_ADDR_USER2 = 12'h00c;
  localparam logic [11:0] TPG_ADDR_USER3 = 12'h010;
  localparam logic [11:0] TPG_ADDR_RAMP  = 12'h014;
  localparam logic [11:0] TPG_ADDR_STAT  = 12'h018;
  localparam logic [11:0] TPG_ADDR_SRST  = 12'h01c;

  // Control field layout
  localparam int TPG_MODE_LSB  = 0;
  localparam int TPG_MODE_MSB  = 3;
  localparam int TPG_POINT_LSB = 4;
  localparam int TPG_POINT_MSB = 5;

  // Status field layout
  localparam int TPG_STAT_DONE_BIT = 16;
  localparam int TPG_STAT_ACT_BIT  = 17;

  // Reset values and soft reset key
  localparam logic [15:0] TPG_USER_RST = 16'h0000;
  localparam logic [15:0] TPG_RAMP_RST = 16'h0000;
  localparam logic [7:0]  TPG_SRST_KEY = 8'h81;

  // Pattern mode codes
  typedef enum logic [3:0] {
    TPG_MODE_OFF  = 4'b0000,
    TPG_MODE_CHK  = 4'b0001,
    TPG_MODE_TOG  = 4'b0010,
    TPG_MODE_LONG = 4'b0100,
    TPG_MODE_SHRT = 4'b0110,
    TPG_MODE_RAMP = 4'b1000,
    TPG_MODE_URPT = 4'b1110,
    TPG_MODE_USGL = 4'b1111
  } tpg_mode_e;

  // Insertion points
  typedef enum logic [1:0] {
    TPG_PT_SAMPLE = 2'b00,
    TPG_PT_SYMBOL = 2'b01,
    TPG_PT_OCTET  = 2'b10,
    TPG_PT_NONE   = 2'b11
  } tpg_point_e;

  // Fixed pattern words per width
  localparam logic [15:0] TPG_CHK16_A = 16'h5555;
  localparam logic [15:0] TPG_CHK16_B = 16'haaaa;
  localparam logic [15:0] TPG_ONE16   = 16'hffff;
  localparam logic [9:0]  TPG_CHK10_A = 10'h155;
  localparam logic [9:0]  TPG_CHK10_B = 10'h2aa;
  localparam logic [9:0]  TPG_ONE10   = 10'h3ff;
  localparam logic [7:0]  TPG_CHK8_A  = 8'h55;
  localparam logic [7:0]  TPG_CHK8_B  = 8'haa;
  localparam logic [7:0]  TPG_ONE8    = 8'hff;

  // Pseudo-random generators: b[n+LEN] = b[n] ^ b[n+TAP]
  localparam int          TPG_SHORT_LEN  = 9;
  localparam int          TPG_SHORT_TAP  = 4;
  localparam logic [8:0]  TPG_SHORT_SEED = 9'h092;
  localparam int          TPG_LONG_LEN   = 23;
  localparam int          TPG_LONG_TAP   = 5;
  localparam logic [22:0] TPG_LONG_SEED  = 23'h003aff;

  // Bits consumed per element at each point
  localparam logic [4:0] TPG_STEP_SAMPLE = 5'd16;
  localparam logic [4:0] TPG_STEP_SYMBOL = 5'd10;
  localparam logic [4:0] TPG_STEP_OCTET  = 5'd8;

  // User single mode stops after the element with this count, the fourth
  localparam logic [15:0] TPG_USER_LAST = 16'd3;

endpackage : tpg_pkg

// ---- verilog/tpg_lfsr.sv ----
`timescale 1ns/100ps
module tpg_lfsr #(
  parameter int             LEN  = 9,
  parameter int             TAP  = 4,
  parameter logic [LEN-1:0] SEED = '0,
  parameter int             OUTW = 16
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_restart,
  input  wire logic            i_advance,
  input  wire logic [4:0]      i_step,
  output logic      [OUTW-1:0] o_bits
);

  logic [LEN-1:0]      state_reg;
  logic [LEN-1:0]      state_next;
  logic [LEN+OUTW-1:0] ext;

  // Unroll the bit stream OUTW bits ahead; state[0] is the oldest bit
  always_comb begin
    ext        = '0;
    state_next = state_reg;
    for (int i = 0; i < LEN; i++) begin
      ext[i] = state_reg[i];
    end
    for (int i = LEN; i < LEN + OUTW; i++) begin
      ext[i] = ext[i-LEN] ^ ext[i-LEN+TAP];
    end
    for (int k = 0; k < OUTW; k++) begin
      o_bits[OUTW-1-k] = ext[k]; // Oldest bit lands in the MSB
    end
    if (i_restart) begin
      state_next = SEED;
    end else if (i_advance) begin
      for (int i = 0; i < LEN; i++) begin
        state_next[i] = ext[int'(i_step) + i];
      end
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= SEED;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : tpg_lfsr

// ---- verilog/tpg_gen.sv ----
`timescale 1ns/100ps
// Function
// R1: Select 01 injects 10-bit symbols
// R2: Select 10 injects 8-bit octets
// R3: Select 00 injects 16-bit frame samples
// R4: Sample ramp is start plus frame number
// R5: Symbol ramp steps by one, 10-bit wrap
// R6: Octet ramp steps by one, 8-bit wrap
// R7: Sample checkerboard and toggle alternate per frame
// R8: Symbol checkerboard 155/2AA, toggle 000/3FF
// R9: Octet checkerboard 55/AA, toggle 00/FF
// R10: Sample short PRBS gives listed frame words
// R11: Sample long PRBS gives listed frame words
// R12: Symbol PRBS sequences start as listed
// R13: Octet PRBS sequences start as listed
// R14: User repeat cycles four words forever
// R15: User single sends four words, then zero
// R16: Symbols take user bits 15 to 6
// R17: Octets take user bits 15 to 9
// R18: Host soft reset returns to normal
// R19: Four-bit code selects the pattern
// R20: Sequences restart on mode or point change
module tpg_gen
  import tpg_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          I_CLK,
  input  wire logic          I_RST,
  input  wire logic          I_PSEL,
  input  wire logic          I_PENABLE,
  input  wire logic          I_PWRITE,
  input  wire logic [AW-1:0] I_PADDR,
  input  wire logic [31:0]   I_PWDATA,
  output logic      [31:0]   O_PRDATA,
  output logic               O_PREADY,
  output logic               O_PSLVERR,
  input  wire logic [15:0]   I_SAMP_C0S0,
  input  wire logic [15:0]   I_SAMP_C0S1,
  input  wire logic [15:0]   I_SAMP_C1S0,
  input  wire logic [15:0]   I_SAMP_C1S1,
  input  wire logic          I_SAMP_VALID,
  input  wire logic [9:0]    I_SYM,
  input  wire logic          I_SYM_VALID,
  input  wire logic [7:0]    I_OCT,
  input  wire logic          I_OCT_VALID,
  output logic      [15:0]   O_SAMP_C0S0,
  output logic      [15:0]   O_SAMP_C0S1,
  output logic      [15:0]   O_SAMP_C1S0,
  output logic      [15:0]   O_SAMP_C1S1,
  output logic               O_SAMP_VALID,
  output logic      [9:0]    O_SYM,
  output logic               O_SYM_VALID,
  output logic      [7:0]    O_OCT,
  output logic               O_OCT_VALID
);

  // Configuration state
  tpg_mode_e   mode_reg;
  tpg_mode_e   mode_next;
  tpg_point_e  point_reg;
  tpg_point_e  point_next;
  logic [15:0] user_reg [4];
  logic [15:0] user_next [4];
  logic [15:0] ramp_reg;
  logic [15:0] ramp_next;
  logic        restart_reg;
  logic        restart_next;
  logic        srst_reg;
  logic        srst_next;

  // APB answer state
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;

  // Sequence state
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        done_reg;
  logic        done_next;

  // Output state
  logic [15:0] samp_reg [4];
  logic [15:0] samp_next [4];
  logic        samp_valid_reg;
  logic [9:0]  sym_reg;
  logic [9:0]  sym_next;
  logic        sym_valid_reg;
  logic [7:0]  oct_reg;
  logic [7:0]  oct_next;
  logic        oct_valid_reg;

  logic        wr_en;
  logic        setup;
  logic        mapped;
  logic        active;
  logic        advance;
  logic        restart;
  logic [4:0]  step;
  logic [15:0] short_bits;
  logic [15:0] long_bits;
  logic [15:0] user_cur;
  logic [15:0] patt16;
  logic [9:0]  patt10;
  logic [7:0]  patt8;
  logic [3:0]  wr_mode;
  logic [1:0]  wr_point;

  assign setup    = I_PSEL && !I_PENABLE;
  assign wr_en    = I_PSEL && I_PENABLE && pready_reg && I_PWRITE;
  assign wr_mode  = I_PWDATA[TPG_MODE_MSB:TPG_MODE_LSB];
  assign wr_point = I_PWDATA[TPG_POINT_MSB:TPG_POINT_LSB];

  // Address decode for the error answer; read data decodes on its own
  always_comb begin
    mapped = 1'b1;
    unique case (I_PADDR[11:0])
      TPG_ADDR_CTRL, TPG_ADDR_USER0, TPG_ADDR_USER1, TPG_ADDR_USER2,
      TPG_ADDR_USER3, TPG_ADDR_RAMP, TPG_ADDR_STAT, TPG_ADDR_SRST: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero-wait slave: answer is prepared in setup, shown in access
  always_comb begin
    pready_next  = setup;
    pslverr_next = setup && !mapped;
    prdata_next  = 32'h0000_0000;
    if (setup && !I_PWRITE) begin
      unique case (I_PADDR[11:0])
        TPG_ADDR_CTRL:  prdata_next = {26'h0, 2'(point_reg), 4'(mode_reg)};
        TPG_ADDR_USER0: prdata_next = {16'h0, user_reg[0]};
        TPG_ADDR_USER1: prdata_next = {16'h0, user_reg[1]};
        TPG_ADDR_USER2: prdata_next = {16'h0, user_reg[2]};
        TPG_ADDR_USER3: prdata_next = {16'h0, user_reg[3]};
        TPG_ADDR_RAMP:  prdata_next = {16'h0, ramp_reg};
        TPG_ADDR_STAT: begin
          prdata_next                    = {16'h0, cnt_reg};
          prdata_next[TPG_STAT_DONE_BIT] = done_reg;
          prdata_next[TPG_STAT_ACT_BIT]  = active;
        end
        default: prdata_next = 32'h0000_0000; // Soft reset reads as zero
      endcase
    end
  end

  // Register writes; returning to mode off needs the soft reset
  always_comb begin
    mode_next    = mode_reg;
    point_next   = point_reg;
    user_next    = user_reg;
    ramp_next    = ramp_reg;
    restart_next = 1'b0;
    srst_next    = 1'b0;
    if (wr_en) begin
      unique case (I_PADDR[11:0])
        TPG_ADDR_CTRL: begin
          if (wr_mode != 4'(TPG_MODE_OFF) || mode_reg == TPG_MODE_OFF) begin
            mode_next = tpg_mode_e'(wr_mode); // [R19]
          end
          point_next   = tpg_point_e'(wr_point);
          restart_next = (mode_next != mode_reg) || (point_next != point_reg); // [R20]
        end
        TPG_ADDR_USER0: user_next[0] = I_PWDATA[15:0];
        TPG_ADDR_USER1: user_next[1] = I_PWDATA[15:0];
        TPG_ADDR_USER2: user_next[2] = I_PWDATA[15:0];
        TPG_ADDR_USER3: user_next[3] = I_PWDATA[15:0];
        TPG_ADDR_RAMP: begin
          ramp_next    = I_PWDATA[15:0];
          restart_next = 1'b1;
        end
        TPG_ADDR_SRST:  srst_next = (I_PWDATA[7:0] == TPG_SRST_KEY); // [R18]
        default: srst_next = 1'b0;
      endcase
    end
  end

  // Configuration registers; soft reset self-clears after one cycle
  always_ff @(posedge I_CLK) begin
    if (I_RST || srst_reg) begin // [R18]
      mode_reg    <= TPG_MODE_OFF;
      point_reg   <= TPG_PT_SAMPLE;
      user_reg    <= '{default: TPG_USER_RST};
      ramp_reg    <= TPG_RAMP_RST;
      restart_reg <= 1'b1;
      srst_reg    <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      point_reg   <= point_next;
      user_reg    <= user_next;
      ramp_reg    <= ramp_next;
      restart_reg <= restart_next;
      srst_reg    <= srst_next;
    end
  end

  // APB answer registers stay alive across the soft reset
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Unsupported codes fall back to pass-through
  always_comb begin
    unique case (mode_reg)
      TPG_MODE_CHK, TPG_MODE_TOG, TPG_MODE_LONG, TPG_MODE_SHRT,
      TPG_MODE_RAMP, TPG_MODE_URPT, TPG_MODE_USGL: active = (point_reg != TPG_PT_NONE);
      default: active = 1'b0;
    endcase
  end

  // Element strobe of the selected point drives the sequence
  always_comb begin
    unique case (point_reg)
      TPG_PT_SAMPLE: begin
        advance = active && I_SAMP_VALID;
        step    = TPG_STEP_SAMPLE;
      end
      TPG_PT_SYMBOL: begin
        advance = active && I_SYM_VALID;
        step    = TPG_STEP_SYMBOL;
      end
      TPG_PT_OCTET: begin
        advance = active && I_OCT_VALID;
        step    = TPG_STEP_OCTET;
      end
      default: begin
        advance = 1'b0;
        step    = TPG_STEP_OCTET;
      end
    endcase
  end

  assign restart = restart_reg || srst_reg;

  // One bit stream serves all widths, so 16, 10 and 8 bit views agree
  tpg_lfsr #(
    .LEN  (TPG_SHORT_LEN),
    .TAP  (TPG_SHORT_TAP),
    .SEED (TPG_SHORT_SEED),
    .OUTW (16)
  ) u_short (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_restart (restart),
    .i_advance (advance && mode_reg == TPG_MODE_SHRT),
    .i_step    (step),
    .o_bits    (short_bits)
  );

  tpg_lfsr #(
    .LEN  (TPG_LONG_LEN),
    .TAP  (TPG_LONG_TAP),
    .SEED (TPG_LONG_SEED),
    .OUTW (16)
  ) u_long (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_restart (restart),
    .i_advance (advance && mode_reg == TPG_MODE_LONG),
    .i_step    (step),
    .o_bits    (long_bits)
  );

  // Element counter and single-shot flag
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = done_reg;
    if (restart) begin
      cnt_next  = 16'h0000; // [R20]
      done_next = 1'b0;
    end else if (advance) begin
      cnt_next = cnt_reg + 16'h0001;
      if (cnt_reg[15:0] == TPG_USER_LAST || cnt_reg[1:0] == 2'(TPG_USER_LAST)) begin
        done_next = done_reg || (cnt_reg[1:0] == 2'(TPG_USER_LAST));
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cnt_reg  <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign user_cur = user_reg[cnt_reg[1:0]]; // [R14]

  // Pattern words for the current element at each width
  always_comb begin
    patt16 = 16'h0000;
    patt10 = 10'h000;
    patt8  = 8'h00;
    unique case (mode_reg)
      TPG_MODE_CHK: begin
        patt16 = cnt_reg[0] ? TPG_CHK16_B : TPG_CHK16_A; // [R7]
        patt10 = cnt_reg[0] ? TPG_CHK10_B : TPG_CHK10_A; // [R8]
        patt8  = cnt_reg[0] ? TPG_CHK8_B : TPG_CHK8_A;   // [R9]
      end
      TPG_MODE_TOG: begin
        patt16 = cnt_reg[0] ? TPG_ONE16 : 16'h0000; // [R7]
        patt10 = cnt_reg[0] ? TPG_ONE10 : 10'h000;  // [R8]
        patt8  = cnt_reg[0] ? TPG_ONE8 : 8'h00;     // [R9]
      end
      TPG_MODE_SHRT: begin
        patt16 = short_bits;        // [R10]
        patt10 = short_bits[15:6];  // [R12]
        patt8  = short_bits[15:8];  // [R13]
      end
      TPG_MODE_LONG: begin
        patt16 = long_bits;         // [R11]
        patt10 = long_bits[15:6];   // [R12]
        patt8  = long_bits[15:8];   // [R13]
      end
      TPG_MODE_RAMP: begin
        patt16 = ramp_reg + cnt_reg;             // [R4]
        patt10 = ramp_reg[9:0] + cnt_reg[9:0];   // [R5]
        patt8  = ramp_reg[7:0] + cnt_reg[7:0];   // [R6]
      end
      TPG_MODE_URPT, TPG_MODE_USGL: begin
        if (mode_reg == TPG_MODE_USGL && done_reg) begin
          patt16 = 16'h0000; // [R15]
          patt10 = 10'h000;  // [R16]
          patt8  = 8'h00;    // [R17]
        end else begin
          patt16 = user_cur;                 // [R14]
          patt10 = user_cur[15:6];           // [R16]
          patt8  = {1'b0, user_cur[15:9]};   // [R17]
        end
      end
      default: patt16 = 16'h0000;
    endcase
  end

  // Substitute only at the selected point; others pass live data
  always_comb begin
    samp_next[0] = I_SAMP_C0S0;
    samp_next[1] = I_SAMP_C0S1;
    samp_next[2] = I_SAMP_C1S0;
    samp_next[3] = I_SAMP_C1S1;
    sym_next     = I_SYM;
    oct_next     = I_OCT;
    if (active && point_reg == TPG_PT_SAMPLE) begin
      samp_next = '{default: patt16}; // [R3]
    end
    if (active && point_reg == TPG_PT_SYMBOL) begin
      sym_next = patt10; // [R1]
    end
    if (active && point_reg == TPG_PT_OCTET) begin
      oct_next = patt8; // [R2]
    end
  end

  // Output registers, one cycle of latency on every path
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      samp_reg       <= '{default: 16'h0000};
      samp_valid_reg <= 1'b0;
      sym_reg        <= 10'h000;
      sym_valid_reg  <= 1'b0;
      oct_reg        <= 8'h00;
      oct_valid_reg  <= 1'b0;
    end else begin
      samp_reg       <= samp_next;
      samp_valid_reg <= I_SAMP_VALID;
      sym_reg        <= sym_next;
      sym_valid_reg  <= I_SYM_VALID;
      oct_reg        <= oct_next;
      oct_valid_reg  <= I_OCT_VALID;
    end
  end

  assign O_PRDATA     = prdata_reg;
  assign O_PREADY     = pready_reg;
  assign O_PSLVERR    = pslverr_reg;
  assign O_SAMP_C0S0  = samp_reg[0];
  assign O_SAMP_C0S1  = samp_reg[1];
  assign O_SAMP_C1S0  = samp_reg[2];
  assign O_SAMP_C1S1  = samp_reg[3];
  assign O_SAMP_VALID = samp_valid_reg;
  assign O_SYM        = sym_reg;
  assign O_SYM_VALID  = sym_valid_reg;
  assign O_OCT        = oct_reg;
  assign O_OCT_VALID  = oct_valid_reg;

endmodule : tpg_gen

// ---- tb/tpg_gen_assertions.sv ----
`timescale 1ns/100ps
module tpg_gen_assertions (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        I_SAMP_VALID,
  input wire logic        O_SAMP_VALID,
  input wire logic        I_SYM_VALID,
  input wire logic        O_SYM_VALID,
  input wire logic        I_OCT_VALID,
  input wire logic        O_OCT_VALID
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  // Bus phases as seen by the slave
  sequence s_setup; I_PSEL && !I_PENABLE; endsequence
  sequence s_answer; I_PSEL && I_PENABLE && O_PREADY; endsequence

  // Zero wait states, so a late ready is a slip
  property p_answer; s_setup |=> s_answer; endproperty
  property p_pulse; s_setup ##1 s_answer |=> !O_PREADY; endproperty
  property p_phase;
    O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PSEL && !I_PENABLE);
  endproperty
  property p_err; O_PSLVERR |-> O_PREADY && (O_PRDATA == 32'h0); endproperty
  // Stream strobes are delayed copies at every point
  property p_samp; I_SAMP_VALID |=> O_SAMP_VALID; endproperty
  property p_sym; I_SYM_VALID |=> O_SYM_VALID; endproperty
  property p_oct; I_OCT_VALID |=> O_OCT_VALID; endproperty
  property p_quiet;
    !I_SAMP_VALID && !I_SYM_VALID && !I_OCT_VALID
      |=> !(O_SAMP_VALID || O_SYM_VALID || O_OCT_VALID);
  endproperty

  a_answer: assert property (p_answer) else $error("ready missing after setup");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_phase: assert property (p_phase) else $error("ready outside access phase");
  a_err: assert property (p_err) else $error("error answer with data");
  a_samp: assert property (p_samp) else $error("frame strobe lost");
  a_sym: assert property (p_sym) else $error("symbol strobe lost");
  a_oct: assert property (p_oct) else $error("octet strobe lost");
  a_quiet: assert property (p_quiet) else $error("spurious strobe");
endmodule : tpg_gen_assertions

bind tpg_gen tpg_gen_assertions u_tpg_gen_assertions (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA),
  .I_SAMP_VALID(I_SAMP_VALID), .O_SAMP_VALID(O_SAMP_VALID),
  .I_SYM_VALID(I_SYM_VALID), .O_SYM_VALID(O_SYM_VALID),
  .I_OCT_VALID(I_OCT_VALID), .O_OCT_VALID(O_OCT_VALID)
);

// ---- tb/tpg_rx_model.sv ----
`timescale 1ns/100ps
// Far-side receiver: takes in the lane of the point under test
module tpg_rx_model (
  input  wire logic [1:0]  i_pt,
  input  wire logic [63:0] i_samp,
  input  wire logic        i_samp_vld,
  input  wire logic [9:0]  i_sym,
  input  wire logic        i_sym_vld,
  input  wire logic [7:0]  i_oct,
  input  wire logic        i_oct_vld,
  output logic             o_got,
  output logic      [63:0] o_word
);
  // Narrow lanes zero-extended so one checker word fits all
  always_comb begin
    case (i_pt)
      2'b00: begin o_got = i_samp_vld; o_word = i_samp; end
      2'b01: begin o_got = i_sym_vld; o_word = {54'h0, i_sym}; end
      default: begin o_got = i_oct_vld; o_word = {56'h0, i_oct}; end
    endcase
  end
endmodule : tpg_rx_model

// ---- tb/tpg_gen_bench.sv ----
`timescale 1ns/100ps
module tpg_gen_bench;
  import tpg_pkg::*;
  logic clk, rst, psel, pen, pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic pready, pslverr, osv, osyv, oov, got;
  logic [15:0] s0, s1, s2, s3, usr[4], ramp;
  logic [9:0] osym;
  logic [7:0] ooct;
  logic [63:0] live, word, expq[$];
  logic [2:0] vld;
  logic [1:0] pt;
  logic [32:0] j;
  int errors, n_checks;
  tpg_mode_e mds[7] = '{TPG_MODE_CHK, TPG_MODE_TOG, TPG_MODE_LONG, TPG_MODE_SHRT,
                        TPG_MODE_RAMP, TPG_MODE_URPT, TPG_MODE_USGL};
  logic [15:0] sht[3][5] = '{'{16'h496f, 16'hc9a9, 16'h980c, 16'h651a, 16'h5fd1},
    '{16'h125, 16'h2fc, 16'h26a, 16'h198, 16'h031}, '{16'h49, 16'h6f, 16'hc9, 16'ha9, 16'h98}};
  logic [15:0] lng[3][5] = '{'{16'hff5c, 16'h0029, 16'hb80a, 16'h3d72, 16'h9b26},
    '{16'h3fd, 16'h1c0, 16'h00a, 16'h1b8, 16'h028}, '{16'hff, 16'h5c, 16'h00, 16'h29, 16'hb8}};

  tpg_gen u_tpg_gen (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SAMP_C0S0(live[63:48]),
    .I_SAMP_C0S1(live[47:32]), .I_SAMP_C1S0(live[31:16]), .I_SAMP_C1S1(live[15:0]),
    .I_SAMP_VALID(vld[0]), .I_SYM(live[9:0]), .I_SYM_VALID(vld[1]), .I_OCT(live[7:0]),
    .I_OCT_VALID(vld[2]), .O_SAMP_C0S0(s0), .O_SAMP_C0S1(s1), .O_SAMP_C1S0(s2),
    .O_SAMP_C1S1(s3), .O_SAMP_VALID(osv), .O_SYM(osym), .O_SYM_VALID(osyv),
    .O_OCT(ooct), .O_OCT_VALID(oov));

  tpg_rx_model u_tpg_rx_model (.i_pt(pt), .i_samp({s0, s1, s2, s3}), .i_samp_vld(osv),
    .i_sym(osym), .i_sym_vld(osyv), .i_oct(ooct), .i_oct_vld(oov), .o_got(got),
    .o_word(word));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nxt();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction : nxt

  // Element n of a run, worked out from the pattern tables
  function automatic logic [63:0] expv(input int p, input tpg_mode_e md, input int n,
                                       input logic [63:0] lv);
    logic [15:0] m, v;
    m = (p == 0) ? 16'hffff : (p == 1) ? 16'h03ff : 16'h00ff;
    case (md)
      TPG_MODE_OFF: return lv;
      TPG_MODE_CHK: v = n[0] ? 16'haaaa : 16'h5555;
      TPG_MODE_TOG: v = n[0] ? 16'hffff : 16'h0000;
      TPG_MODE_RAMP: v = ramp + 16'(n);
      TPG_MODE_LONG: v = lng[p][n];
      TPG_MODE_SHRT: v = sht[p][n];
      default: v = (md == TPG_MODE_USGL && n > 3) ? 16'h0000 :
                   usr[n % 4] >> ((p == 0) ? 0 : (p == 1) ? 6 : 9);
    endcase
    v = v & m;
    return (p == 0) ? {4{v}} : {48'h0, v};
  endfunction : expv

  task automatic cmp_reg(input logic [32:0] g, input logic [32:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t reg got %h exp %h", $time, g, e);
    end
  endtask : cmp_reg

  task automatic cmp_data(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t data got %h exp %h", $time, g, e);
    end
  endtask : cmp_data

  // One bus transfer; request held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [32:0] r);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    cmp_reg({32'h0, pready}, 33'h1); // A missing answer counts as a fault
    r = {pslverr, prdata};
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp_reg(r, e);
  endtask : rdc

  // Five elements with random gaps; the note goes in the queue
  task automatic send(input int p, input tpg_mode_e md);
    logic [31:0] r;
    int k;
    pt = 2'(p);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      r = nxt();
      if (r[0]) begin
        @(posedge clk);
        vld <= 3'b000;
      end
      @(posedge clk);
      vld <= 3'b001 << p;
      live <= {r, ~r};
      expq.push_back(expv(p, md, i, {r, ~r}));
    end
    @(posedge clk);
    vld <= 3'b000;
    k = 0;
    while (expq.size() != 0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    cmp_data(64'(expq.size()), 64'h0); // Every element arrived
  endtask : send

  // Receiver side: oldest note against each arriving element
  always @(posedge clk) begin
    if (got === 1'b1) begin
      if (expq.size() == 0) cmp_data(word, ~word);
      else cmp_data(word, expq.pop_front());
    end
  end

  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    {rst, psel, pen, pwr, paddr, pwdata, live, vld, pt} = '0;
    rst = 1'b1;
    seed = 32'ha73cfa48;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(TPG_ADDR_CTRL, 33'h0); // Off after reset
    send(0, TPG_MODE_OFF);
    // Full words written, only low half must stick
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, TPG_ADDR_USER0 + 12'(4 * i), nxt(), j);
      usr[i] = seed[15:0];
    end
    apb(1'b1, TPG_ADDR_RAMP, nxt(), j);
    ramp = seed[15:0];
    rdc(TPG_ADDR_USER0, {17'h0, usr[0]}); // User word readback
    rdc(12'h100, {1'b1, 32'h0});
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 7; m++) begin
        apb(1'b1, TPG_ADDR_CTRL, {26'h0, 2'(p), mds[m]}, j); // Select
        send(p, mds[m]); // Run
      end
    end
    // A zero mode code is refused while a pattern runs
    apb(1'b1, TPG_ADDR_CTRL, 32'h0, j);
    rdc(TPG_ADDR_CTRL, 33'h0f); // Mode kept
    rdc(TPG_ADDR_STAT, 33'h0_0002_0000); // Active, count restarted
    apb(1'b1, TPG_ADDR_SRST, 32'h81, j); // Host soft reset
    rdc(TPG_ADDR_CTRL, 33'h0); // Back to normal
    rdc(TPG_ADDR_USER0, 33'h0); // Config cleared
    send(0, TPG_MODE_OFF); // Live data again
    // Point 11 and unknown mode codes leave live data alone
    apb(1'b1, TPG_ADDR_CTRL, 32'h31, j);
    send(0, TPG_MODE_OFF);
    apb(1'b1, TPG_ADDR_CTRL, 32'h03, j);
    send(0, TPG_MODE_OFF);
    print_verdict();
  end
endmodule : tpg_gen_bench
